/* File: logic/rtcal_defs.vh */
// rtcal_defs.vh: register map, field masks, reset values and bus constants
// for the calendar and alarm block; included by every design file of it.
`ifndef RTCAL_DEFS_VH
`define RTCAL_DEFS_VH

// register addresses
`define RTCAL_ADDR_SECONDS   8'h04
`define RTCAL_ADDR_MINUTES   8'h05
`define RTCAL_ADDR_HOURS     8'h06
`define RTCAL_ADDR_DAYS      8'h07
`define RTCAL_ADDR_WEEKDAYS  8'h08
`define RTCAL_ADDR_MONTH     8'h09
`define RTCAL_ADDR_YEAR      8'h0A
`define RTCAL_ADDR_SEC_MATCH 8'h0B
`define RTCAL_ADDR_MIN_MATCH 8'h0C
`define RTCAL_ADDR_HR_MATCH  8'h0D
`define RTCAL_ADDR_DAY_MATCH 8'h0E

// writable bits per register
`define RTCAL_MASK_SECONDS   8'h7F
`define RTCAL_MASK_MINUTES   8'h7F
`define RTCAL_MASK_HOURS     8'h3F
`define RTCAL_MASK_DAYS      8'h3F
`define RTCAL_MASK_WEEKDAYS  8'h07
`define RTCAL_MASK_MONTH     8'h1F
`define RTCAL_MASK_YEAR      8'hFF
`define RTCAL_MASK_SEC_MATCH 8'hFF
`define RTCAL_MASK_MIN_MATCH 8'hFF
`define RTCAL_MASK_HR_MATCH  8'hBF
`define RTCAL_MASK_DAY_MATCH 8'hBF

// field positions
`define RTCAL_BIT_DISABLE    7
`define RTCAL_BIT_AFTERNOON  5

// reset values
`define RTCAL_RST_TIME       8'h00
`define RTCAL_RST_DAY        8'h01
`define RTCAL_RST_MONTH      8'h01
`define RTCAL_RST_YEAR       8'h00
`define RTCAL_RST_MATCH      8'h80

// bus: 7-bit device address, write A2h / read A3h
`define RTCAL_DEV_ADDR       7'h51

`endif

/* File: logic/rtcal_i2c.v */
// rtcal_i2c.v: two-wire serial slave byte engine for the calendar block.
// assumes scl/sda come from pins (synchronised here) and that mclk is many
// times faster than scl, so every edge of scl is seen as a sampled change.
`include "rtcal_defs.vh"
`default_nettype none
module rtcal_i2c (
   // clock and reset
   input  wire       mclk,
   input  wire       sys_rst,
   // pins
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_out,
   output reg        sda_oe,
   // register side
   input  wire [7:0] rd_data,
   output reg        rd_stb,
   output reg        wr_stb,
   output reg        wr_first,
   output reg  [7:0] wr_data,
   output reg        busy
);
   localparam S_IDLE = 3'd0;
   localparam S_ADDR = 3'd1;
   localparam S_AACK = 3'd2;
   localparam S_WR   = 3'd3;
   localparam S_WACK = 3'd4;
   localparam S_RD   = 3'd5;
   localparam S_RACK = 3'd6;

   reg [2:0] state_reg;
   reg [2:0] cnt_reg;
   reg [7:0] sh_reg;
   reg [7:0] tx_reg;
   reg       got_reg;
   reg       rw_reg;
   reg       nack_reg;
   reg       scl_s1, scl_s2, scl_d;
   reg       sda_s1, sda_s2, sda_d;

   wire scl_rise = scl_s2 & ~scl_d;
   wire scl_fall = ~scl_s2 & scl_d;
   wire start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
   wire stop_ev  = scl_s2 & scl_d & ~sda_d & sda_s2;

   // pins pass two flops; the second stage and a third delay flop feed logic
   always @(posedge mclk) begin
      if (sys_rst) begin
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
      end else begin
         {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= S_IDLE;
         cnt_reg   <= 3'h0;
         sh_reg    <= 8'h00;
         tx_reg    <= 8'h00;
         got_reg   <= 1'b0;
         rw_reg    <= 1'b0;
         nack_reg  <= 1'b0;
         sda_out   <= 1'b0;
         sda_oe    <= 1'b0;
         rd_stb    <= 1'b0;
         wr_stb    <= 1'b0;
         wr_first  <= 1'b0;
         wr_data   <= 8'h00;
         busy      <= 1'b0;
      end else begin
         rd_stb <= 1'b0;
         wr_stb <= 1'b0;
         if (stop_ev) begin
            state_reg <= S_IDLE;
            sda_oe    <= 1'b0;
            busy      <= 1'b0;
         end else if (start_ev) begin
            // repeated start keeps busy high: the access is one transaction
            state_reg <= S_ADDR;
            cnt_reg   <= 3'h0;
            got_reg   <= 1'b0;
            sda_oe    <= 1'b0;
         end else begin
            case (state_reg)
               S_ADDR, S_WR: begin
                  if (scl_rise) begin
                     sh_reg  <= {sh_reg[6:0], sda_s2};
                     cnt_reg <= cnt_reg + 3'h1;
                     got_reg <= (cnt_reg == 3'h7);
                  end else if (scl_fall && got_reg) begin
                     got_reg <= 1'b0;
                     if (state_reg == S_WR) begin
                        wr_stb    <= 1'b1;
                        wr_data   <= sh_reg;
                        sda_oe    <= 1'b1;
                        state_reg <= S_WACK;
                     end else if (sh_reg[7:1] == `RTCAL_DEV_ADDR) begin
                        rw_reg    <= sh_reg[0];
                        wr_first  <= ~sh_reg[0];
                        busy      <= 1'b1;
                        sda_oe    <= 1'b1;
                        state_reg <= S_AACK;
                     end else begin
                        busy      <= 1'b0;
                        state_reg <= S_IDLE;
                     end
                  end
               end
               S_AACK, S_WACK: begin
                  if (scl_fall) begin
                     cnt_reg <= 3'h0;
                     if (state_reg == S_WACK)
                        wr_first <= 1'b0;
                     if (state_reg == S_AACK && rw_reg) begin
                        tx_reg    <= rd_data;
                        rd_stb    <= 1'b1;
                        sda_oe    <= ~rd_data[7];
                        state_reg <= S_RD;
                     end else begin
                        sda_oe    <= 1'b0;
                        state_reg <= S_WR;
                     end
                  end
               end
               S_RD: begin
                  if (scl_fall) begin
                     if (cnt_reg == 3'h7) begin
                        sda_oe    <= 1'b0;
                        state_reg <= S_RACK;
                     end else begin
                        tx_reg  <= {tx_reg[6:0], 1'b0};
                        sda_oe  <= ~tx_reg[6];
                        cnt_reg <= cnt_reg + 3'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise)
                     nack_reg <= sda_s2;
                  else if (scl_fall) begin
                     cnt_reg <= 3'h0;
                     if (!nack_reg) begin
                        tx_reg    <= rd_data;
                        rd_stb    <= 1'b1;
                        sda_oe    <= ~rd_data[7];
                        state_reg <= S_RD;
                     end else
                        state_reg <= S_IDLE;
                  end
               end
               default: begin
                  state_reg <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: logic/rtcal_top.v */
// rtcal_top.v: calendar counters (seconds to years), access blocking and
// second/minute/hour/day alarm compare, reached over the two-wire pins.
// assumes tick_1hz is a one-cycle pulse on mclk and alarm_clear and
// hour_mode_12 come from logic on mclk.
`include "rtcal_defs.vh"
`default_nettype none
module rtcal_top (
   // clock and reset
   input  wire mclk,
   input  wire sys_rst,
   // two-wire pins
   input  wire scl_in,
   input  wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   // time base and control
   input  wire tick_1hz,
   input  wire hour_mode_12,
   input  wire alarm_clear,
   // status
   output reg  alarm_hit_flag,
   output reg  time_frozen
);
   reg  [7:0] sec_reg, min_reg, hour_reg, day_reg, wday_reg, month_count, year_count;
   reg  [7:0] second_match, minute_match, hour_match, day_match;
   reg  [7:0] ptr_reg;
   reg        pend_reg;
   reg        step_reg;
   reg  [7:0] sec_next, min_next, hour_next, day_next, wday_next, month_next, year_next;
   reg  [7:0] rd_mux;
   wire       rd_stb, wr_stb, wr_first, busy;
   wire [7:0] wr_data;
   wire       advance;
   wire       second_compare_disable, minute_compare_disable;
   wire       hour_compare_disable, day_compare_disable;
   wire       all_match;

   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // leap: year BCD divisible by 4 when units even and units bit 1 equals tens bit 0
   function [7:0] month_end;
      input [7:0] mon;
      input [7:0] yr;
      begin
         case (mon)
            8'h02:   month_end = (~yr[0] & (yr[1] == yr[4])) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11:
                     month_end = 8'h30;
            default: month_end = 8'h31;
         endcase
      end
   endfunction

   // 12-hour: 11 flips afternoon and goes to 12, 12 goes to 01; 24-hour wraps 23 to 00
   function [7:0] hour_step;
      input [7:0] h;
      input       mode12;
      begin
         if (mode12) begin
            if (h[4:0] == 5'h12)
               hour_step = {2'h0, h[5], 5'h01};
            else if (h[4:0] == 5'h11)
               hour_step = {2'h0, ~h[5], 5'h12};
            else
               hour_step = {2'h0, h[5], 5'h00} | (bcd_inc({3'h0, h[4:0]}) & 8'h1F);
         end else if (h == 8'h23)
            hour_step = 8'h00;
         else
            hour_step = bcd_inc(h);
      end
   endfunction

   rtcal_i2c u_bus (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_out  (sda_out),
      .sda_oe   (sda_oe),
      .rd_data  (rd_mux),
      .rd_stb   (rd_stb),
      .wr_stb   (wr_stb),
      .wr_first (wr_first),
      .wr_data  (wr_data),
      .busy     (busy)
   );

   assign advance = ~busy & (tick_1hz | pend_reg);

   always @* begin
      sec_next   = sec_reg;
      min_next   = min_reg;
      hour_next  = hour_reg;
      day_next   = day_reg;
      wday_next  = wday_reg;
      month_next = month_count;
      year_next  = year_count;
      if (advance) begin
         sec_next = (sec_reg == 8'h59) ? 8'h00 : bcd_inc(sec_reg);
         if (sec_reg == 8'h59) begin
            min_next = (min_reg == 8'h59) ? 8'h00 : bcd_inc(min_reg);
            if (min_reg == 8'h59) begin
               hour_next = hour_step(hour_reg, hour_mode_12);
               if (hour_mode_12 ? (hour_reg == 8'h31) : (hour_reg == 8'h23)) begin
                  wday_next = (wday_reg == 8'h06) ? 8'h00 : wday_reg + 8'h01;
                  day_next  = (day_reg == month_end(month_count, year_count)) ? 8'h01 : bcd_inc(day_reg);
                  if (day_reg == month_end(month_count, year_count)) begin
                     month_next = (month_count == 8'h12) ? 8'h01 : bcd_inc(month_count);
                     if (month_count == 8'h12)
                        year_next = (year_count == 8'h99) ? 8'h00 : bcd_inc(year_count);
                  end
               end
            end
         end
      end
   end

   // unmapped addresses read zero
   always @* begin
      case (ptr_reg)
         `RTCAL_ADDR_SECONDS:   rd_mux = sec_reg;
         `RTCAL_ADDR_MINUTES:   rd_mux = min_reg;
         `RTCAL_ADDR_HOURS:     rd_mux = hour_reg;
         `RTCAL_ADDR_DAYS:      rd_mux = day_reg;
         `RTCAL_ADDR_WEEKDAYS:  rd_mux = wday_reg;
         `RTCAL_ADDR_MONTH:     rd_mux = month_count & `RTCAL_MASK_MONTH;
         `RTCAL_ADDR_YEAR:      rd_mux = year_count;
         `RTCAL_ADDR_SEC_MATCH: rd_mux = second_match;
         `RTCAL_ADDR_MIN_MATCH: rd_mux = minute_match;
         `RTCAL_ADDR_HR_MATCH:  rd_mux = hour_match;
         `RTCAL_ADDR_DAY_MATCH: rd_mux = day_match;
         default:               rd_mux = 8'h00;
      endcase
   end

   assign second_compare_disable = second_match[`RTCAL_BIT_DISABLE];
   assign minute_compare_disable = minute_match[`RTCAL_BIT_DISABLE];
   assign hour_compare_disable   = hour_match[`RTCAL_BIT_DISABLE];
   assign day_compare_disable    = day_match[`RTCAL_BIT_DISABLE];

   // hour alarm shares the counter format
   assign all_match = ~(second_compare_disable & minute_compare_disable &
                        hour_compare_disable & day_compare_disable) &
                      (second_compare_disable | (second_match[6:0] == sec_reg[6:0])) &
                      (minute_compare_disable | (minute_match[6:0] == min_reg[6:0])) &
                      (hour_compare_disable   | (hour_match[5:0]   == hour_reg[5:0])) &
                      (day_compare_disable    | (day_match[5:0]    == day_reg[5:0]));

   always @(posedge mclk) begin
      if (sys_rst) begin
         sec_reg        <= `RTCAL_RST_TIME;
         min_reg        <= `RTCAL_RST_TIME;
         hour_reg       <= `RTCAL_RST_TIME;
         day_reg        <= `RTCAL_RST_DAY;
         wday_reg       <= `RTCAL_RST_TIME;
         month_count    <= `RTCAL_RST_MONTH;
         year_count     <= `RTCAL_RST_YEAR;
         second_match   <= `RTCAL_RST_MATCH;
         minute_match   <= `RTCAL_RST_MATCH;
         hour_match     <= `RTCAL_RST_MATCH;
         day_match      <= `RTCAL_RST_MATCH;
         ptr_reg        <= 8'h00;
         pend_reg       <= 1'b0;
         step_reg       <= 1'b0;
         alarm_hit_flag <= 1'b0;
         time_frozen    <= 1'b0;
      end else begin
         time_frozen <= busy;
         // one request kept; a longer access drops the extra ticks
         if (busy && tick_1hz)
            pend_reg <= 1'b1;
         else if (advance)
            pend_reg <= 1'b0;
         sec_reg     <= sec_next;
         min_reg     <= min_next;
         hour_reg    <= hour_next;
         day_reg     <= day_next;
         wday_reg    <= wday_next;
         month_count <= month_next;
         year_count  <= year_next;
         // step_reg marks the cycle the new time is visible to the compare
         step_reg    <= advance;
         // set only on a step into a match; set beats clear
         if (step_reg && all_match)
            alarm_hit_flag <= 1'b1;
         else if (alarm_clear)
            alarm_hit_flag <= 1'b0;
         if (rd_stb)
            ptr_reg <= ptr_reg + 8'h01;
         if (wr_stb && wr_first)
            ptr_reg <= wr_data;
         else if (wr_stb) begin
            ptr_reg <= ptr_reg + 8'h01;
            // writes land only while busy, so they never meet a counter step
            case (ptr_reg)
               `RTCAL_ADDR_SECONDS:   sec_reg      <= wr_data & `RTCAL_MASK_SECONDS;
               `RTCAL_ADDR_MINUTES:   min_reg      <= wr_data & `RTCAL_MASK_MINUTES;
               `RTCAL_ADDR_HOURS:     hour_reg     <= wr_data & `RTCAL_MASK_HOURS;
               `RTCAL_ADDR_DAYS:      day_reg      <= wr_data & `RTCAL_MASK_DAYS;
               `RTCAL_ADDR_WEEKDAYS:  wday_reg     <= wr_data & `RTCAL_MASK_WEEKDAYS;
               `RTCAL_ADDR_MONTH:     month_count  <= wr_data & `RTCAL_MASK_MONTH;
               `RTCAL_ADDR_YEAR:      year_count   <= wr_data & `RTCAL_MASK_YEAR;
               `RTCAL_ADDR_SEC_MATCH: second_match <= wr_data & `RTCAL_MASK_SEC_MATCH;
               `RTCAL_ADDR_MIN_MATCH: minute_match <= wr_data & `RTCAL_MASK_MIN_MATCH;
               `RTCAL_ADDR_HR_MATCH:  hour_match   <= wr_data & `RTCAL_MASK_HR_MATCH;
               `RTCAL_ADDR_DAY_MATCH: day_match    <= wr_data & `RTCAL_MASK_DAY_MATCH;
               default: begin
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/rtc_calendar_and_alarm_regs_test.sv */
// rtc_calendar_and_alarm_regs_test.sv: register, calendar and alarm tests of
// rtcal_top over the two-wire pins; assumes the host model as bus master.
`default_nettype none
module rtc_calendar_and_alarm_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic       mclk;
   logic       sys_rst;
   logic       tick_1hz;
   logic       hour_mode_12;
   logic       alarm_clear;
   logic       a;
   logic [7:0] b;
   logic [7:0] yrs[3] = '{8'h00, 8'h04, 8'h01};
   logic [7:0] e_day[3] = '{8'h29, 8'h29, 8'h01};
   logic [7:0] e_mon[3] = '{8'h02, 8'h02, 8'h03};
   int         fails;
   int         n_checks;
   wire        sda_out;
   wire        sda_oe;
   wire        alarm_hit_flag;
   wire        time_frozen;
   wire        scl_drv;
   wire        sda_pull;
   // open drain with pull-up: released means high
   wire        sda_line = sda_pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);
   rtcal_top u_rtcal_top (.mclk, .sys_rst, .scl_in(scl_drv), .sda_in(sda_line), .sda_out, .sda_oe,
      .tick_1hz, .hour_mode_12, .alarm_clear, .alarm_hit_flag, .time_frozen);
   rtcal_host_model u_rtcal_host_model (.sda_line, .scl_drv, .sda_pull);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task check(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask
   task wr(input logic [7:0] ptr, input logic [7:0] d[$]);
      u_rtcal_host_model.start();
      u_rtcal_host_model.wbyte(8'hA2, a);
      check("address ack", 8'h01, {7'h00, a});
      u_rtcal_host_model.wbyte(ptr, a);
      foreach (d[i])
         u_rtcal_host_model.wbyte(d[i], a);
      u_rtcal_host_model.stop();
   endtask
   task rd(input logic [7:0] ptr, input logic [7:0] e[$]);
      u_rtcal_host_model.start();
      u_rtcal_host_model.wbyte(8'hA2, a);
      u_rtcal_host_model.wbyte(ptr, a);
      u_rtcal_host_model.start();
      u_rtcal_host_model.wbyte(8'hA3, a);
      foreach (e[i]) begin
         u_rtcal_host_model.rbyte(i == e.size() - 1, b);
         check($sformatf("reg %h", ptr + 8'(i)), e[i], b);
      end
      u_rtcal_host_model.stop();
   endtask
   task tick();
      @(posedge mclk) tick_1hz <= 1'b1;
      @(posedge mclk) tick_1hz <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask
   // bounded wait; running out shows as a mismatch
   task flag_is(input logic exp);
      for (int k = 0; k < 10 && alarm_hit_flag !== exp; k++)
         @(posedge mclk);
      check("alarm_hit_flag", {7'h00, exp}, {7'h00, alarm_hit_flag});
   endtask
   task finish_test();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      fails = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      tick_1hz = 1'b0;
      hour_mode_12 = 1'b0;
      alarm_clear = 1'b0;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge mclk);
      rd(8'h04, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
      rd(8'h0B, '{8'h80, 8'h80, 8'h80, 8'h80});
      rd(8'h20, '{8'h00});
      wr(8'h09, '{8'hFF, 8'h27, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
      rd(8'h09, '{8'h1F, 8'h27, 8'hFF, 8'hFF, 8'hBF, 8'hBF});
      wr(8'h04, '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
      tick();
      rd(8'h04, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
      foreach (yrs[i]) begin
         wr(8'h04, '{8'h59, 8'h59, 8'h23, 8'h28, 8'h00, 8'h02, yrs[i]});
         tick();
         rd(8'h07, '{e_day[i], 8'h01, e_mon[i]});
      end
      // two ticks inside one open access must land as a single step
      wr(8'h04, '{8'h10});
      u_rtcal_host_model.start();
      u_rtcal_host_model.wbyte(8'hA2, a);
      u_rtcal_host_model.wbyte(8'h04, a);
      tick();
      tick();
      check("time_frozen", 8'h01, {7'h00, time_frozen});
      u_rtcal_host_model.start();
      u_rtcal_host_model.wbyte(8'hA3, a);
      u_rtcal_host_model.rbyte(1'b1, b);
      check("frozen seconds", 8'h10, b);
      u_rtcal_host_model.stop();
      repeat (8) @(posedge mclk);
      rd(8'h04, '{8'h11});
      wr(8'h04, '{8'h10, 8'h00, 8'h00});
      wr(8'h0B, '{8'h11, 8'h05, 8'h80, 8'h80});
      tick();
      flag_is(1'b0);
      wr(8'h04, '{8'h10});
      wr(8'h0C, '{8'h80});
      flag_is(1'b0);
      tick();
      flag_is(1'b1);
      tick();
      flag_is(1'b1);
      @(posedge mclk) alarm_clear <= 1'b1;
      @(posedge mclk) alarm_clear <= 1'b0;
      flag_is(1'b0);
      tick();
      flag_is(1'b0);
      @(posedge mclk) hour_mode_12 <= 1'b1;
      wr(8'h04, '{8'h59, 8'h59, 8'h11});
      wr(8'h0B, '{8'h80, 8'h80, 8'h32, 8'h80});
      tick();
      flag_is(1'b1);
      rd(8'h06, '{8'h32});
      wr(8'h04, '{8'h59, 8'h59, 8'h21});
      tick();
      rd(8'h06, '{8'h22});
      finish_test();
   end
endmodule
`default_nettype wire

/* File: verif/rtcal_host_model.sv */
// rtcal_host_model.sv: two-wire bus master standing in for the host.
// assumes the bench resolves sda from both pulls with a pull-up.
`default_nettype none
module rtcal_host_model (
   // wire levels
   input  wire logic sda_line,
   output var  logic scl_drv,
   output var  logic sda_pull
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl_drv = 1'b1;
      sda_pull = 1'b0;
   end
   // quarter of the 80 ns serial clock
   task q();
      #20;
   endtask
   // start or repeated start
   // non-blocking so a change that lands on an mclk edge is not raced
   task start();
      sda_pull <= 1'b0;
      q();
      scl_drv <= 1'b1;
      q();
      sda_pull <= 1'b1;
      q();
      scl_drv <= 1'b0;
      q();
   endtask
   task stop();
      sda_pull <= 1'b1;
      q();
      scl_drv <= 1'b1;
      q();
      sda_pull <= 1'b0;
      q();
   endtask
   // a bit takes 80 ns, so any access ends far inside one second
   task bit_io(input logic pull, output logic seen);
      sda_pull <= pull;
      q();
      scl_drv <= 1'b1;
      q();
      seen = sda_line;
      q();
      scl_drv <= 1'b0;
      q();
   endtask
   task wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(~b[i], s);
      bit_io(1'b0, s);
      ack = ~s;
   endtask
   // reads chain on with auto-increment inside one access
   task rbyte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b0, s);
         b[i] = s;
      end
      bit_io(~last, s);
   endtask
endmodule
`default_nettype wire

/* File: verif/rtcal_props.sv */
// rtcal_props.sv: bus and alarm checks on the ports of rtcal_top.
// assumes pins, tick and clear arrive as rtcal_top expects them.
`default_nettype none
module rtcal_props (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // two-wire pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // time base, control and status
   input wire logic tick_1hz,
   input wire logic hour_mode_12,
   input wire logic alarm_clear,
   input wire logic alarm_hit_flag,
   input wire logic time_frozen
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] since_step;
   // cycles since a tick or an open access, so a flag rise can be traced to a step
   always_ff @(posedge mclk) begin
      if (sys_rst || tick_1hz || time_frozen)
         since_step <= 4'h0;
      else if (since_step != 4'hF)
         since_step <= since_step + 4'h1;
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   chk_reset_quiet:
      assert property ($fell(sys_rst) |-> !sda_oe && !alarm_hit_flag && !time_frozen)
      else $error("outputs not idle after reset");
   chk_drive_low:
      assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   chk_flag_holds:
      assert property (alarm_hit_flag && !alarm_clear |=> alarm_hit_flag)
      else $error("alarm flag dropped without clear");
   chk_flag_cause:
      assert property ($rose(alarm_hit_flag) |-> since_step <= 4'h5)
      else $error("alarm flag set without a time step");
   chk_clear_drops:
      assert property (alarm_clear && since_step > 4'h3 |=> !alarm_hit_flag)
      else $error("alarm flag survived clear");
   chk_ack_in_access:
      assert property ($rose(sda_oe) |-> ##[0:6] time_frozen)
      else $error("device drove data outside an access");
   chk_oe_scl_low:
      assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data changed while serial clock high");
   chk_release_idle:
      assert property ($fell(time_frozen) |-> scl_in && sda_in)
      else $error("counters released before stop");
endmodule
bind rtcal_top rtcal_props u_rtcal_props (.mclk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe,
   .tick_1hz, .hour_mode_12, .alarm_clear, .alarm_hit_flag, .time_frozen);
`default_nettype wire
